/* src/drrb_defs.vh */
/*
 * Constants of the device report reader: command fields, report layout,
 * register map, reset values.
 * Assumes it is included once per file by its bare name.
 */
`ifndef DRRB_DEFS_VH
`define DRRB_DEFS_VH

// ************************************************************
// Command descriptor fields
// ************************************************************
`define DRRB_OPCODE 8'h3c
`define DRRB_MODE 5'h01
`define DRRB_BUF_ID 8'h01
`define DRRB_ALLOC_LEN 24'h000200
`define DRRB_KEY_ARM 24'h000001
`define DRRB_KEY_FETCH 24'h000002

// ************************************************************
// Report layout
// ************************************************************
`define DRRB_RPT_BYTES 10'h200
`define DRRB_RPT_LAST 9'h1ff
`define DRRB_RPT_DEF_END 9'h054
`define DRRB_RPT_WORDS 21

// ************************************************************
// Register map (word index) and reset values
// ************************************************************
`define DRRB_REG_RPT_LAST 5'h14
`define DRRB_REG_CTRL 5'h18
`define DRRB_REG_STATUS 5'h19
`define DRRB_CTRL_RST 32'h00000001
`define DRRB_CTRL_EN_BIT 0

`endif

/* src/drrb_byte_buf.v */
/*
 * Two-entry buffer for report bytes with a last marker.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module drrb_byte_buf (
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Fill side
    input wire in_valid_i,
    input wire [8:0] in_data_i,
    output reg in_ready_o,
    // Drain side
    output reg out_valid_o,
    output reg [8:0] out_data_o,
    input wire out_ready_i
);

reg [8:0] spare_q;
reg [1:0] count_q;
reg [1:0] count_d;
wire push;
wire pop;

assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;

// Occupancy after this cycle
always @*
begin
    count_d = count_q;
    if (push && !pop)
        count_d = count_q + 2'd1;
    else if (pop && !push)
        count_d = count_q - 2'd1;
end

// Head entry drives the output, spare holds the second word
always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        count_q <= 2'd0;
        spare_q <= 9'h000;
        out_data_o <= 9'h000;
        out_valid_o <= 1'b0;
        in_ready_o <= 1'b0;
    end
    else
    begin
        count_q <= count_d;
        out_valid_o <= (count_d != 2'd0);
        in_ready_o <= (count_d != 2'd2);
        if (pop)
        begin
            if (count_q == 2'd2)
                out_data_o <= spare_q;
            else if (push)
                out_data_o <= in_data_i;
        end
        else if (push)
        begin
            if (count_q == 2'd0)
                out_data_o <= in_data_i;
            else
                spare_q <= in_data_i;
        end
        if (pop && push && count_q == 2'd2)
            spare_q <= in_data_i;
    end
end

endmodule // drrb_byte_buf

/* src/drrb_report.v */
/*
 * Device report reader: checks report request descriptors, tracks the
 * two-step request sequence and streams the 512-byte report or zeros.
 * Assumes one 200 MHz clock, a synchronous reset, firmware filling the
 * report words over Avalon-MM, and a byte sink with valid/ready.
 */
`timescale 1ns/1ps
`include "drrb_defs.vh"

// Functional notes
// [RULE_01] Request: opcode, mode, buffer_identifier, key offset
// [RULE_02] Allocation length must be 512 bytes
// [RULE_03] Bad argument or order returns zeros
// [RULE_04] Resets return sequence to start
// [RULE_05] Host restarts whole sequence after reset
// [RULE_06] Unrelated commands keep sequence progress
// [RULE_07] Average erase counts at 0, 4, 8
// [RULE_08] Read reclaim counts at 12, 16, 20
// [RULE_09] Factory bad blocks at 24
// [RULE_10] Runtime bad blocks at 28, 32, 36
// [RULE_11] Secure upgrade count at 40
// [RULE_12] Release date 44, release time 56
// [RULE_13] Host write total at 64
// [RULE_14] Power-off drops at 68
// [RULE_15] Droop indications at 72
// [RULE_16] Dropped host data events at 76
// [RULE_17] Droop recoveries at 80
// [RULE_18] Little-endian fields, undefined bytes zero
module drrb_report (
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Avalon-MM register slave
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Command port
    input wire cmd_valid_i,
    input wire [71:0] cmd_cdb_i,
    input wire reset_command_i,
    output reg cmd_ready_o,
    output reg cmd_taken_o,
    // Report byte stream
    output wire data_valid_o,
    output wire [7:0] data_byte_o,
    output wire data_last_o,
    input wire data_ready_i
);

// ************************************************************
// States
// ************************************************************
localparam SEQ_IDLE = 2'b01;
localparam SEQ_ARMED = 2'b10;
localparam XF_IDLE = 2'b01;
localparam XF_SEND = 2'b10;

// ************************************************************
// Functions
// ************************************************************
// Three-byte field, most significant byte first in the descriptor
function [23:0] cdb_field24;
    input [71:0] cdb;
    input [3:0] first;
    begin
        case (first)
            4'd3: cdb_field24 = {cdb[31:24], cdb[39:32], cdb[47:40]};
            4'd6: cdb_field24 = {cdb[55:48], cdb[63:56], cdb[71:64]};
            default: cdb_field24 = 24'h000000;
        endcase
    end
endfunction

// Byte lane of a word, lane 0 is the least significant byte
function [7:0] lane_of;
    input [31:0] word;
    input [1:0] lane;
    begin
        case (lane)
            2'd0: lane_of = word[7:0];
            2'd1: lane_of = word[15:8];
            2'd2: lane_of = word[23:16];
            default: lane_of = word[31:24];
        endcase
    end
endfunction

// Byte-enable merge of a write into a stored word
function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] be;
    begin
        merge_be[7:0] = be[0] ? wdata[7:0] : old[7:0];
        merge_be[15:8] = be[1] ? wdata[15:8] : old[15:8];
        merge_be[23:16] = be[2] ? wdata[23:16] : old[23:16];
        merge_be[31:24] = be[3] ? wdata[31:24] : old[31:24];
    end
endfunction

// ************************************************************
// Storage and state
// ************************************************************
reg [31:0] rpt_mem_q [0:`DRRB_RPT_WORDS-1];
reg [31:0] ctrl_q;
reg [1:0] seq_q;
reg [1:0] xf_q;
reg zero_fill_q;
reg [8:0] idx_q;
reg [15:0] served_q;
reg [15:0] rejected_q;
integer i;

wire buf_in_ready;
wire [8:0] buf_out;
wire report_en;
wire [7:0] op_byte;
wire [4:0] mode_bits;
wire [7:0] id_byte;
wire [23:0] key_val;
wire [23:0] alloc_val;
wire is_ours;
wire args_ok;
wire take_cmd;
wire push;
wire [7:0] next_byte;
wire bus_req;
wire bus_ack;
wire rpt_hit;

assign report_en = ctrl_q[`DRRB_CTRL_EN_BIT];

// ************************************************************
// Descriptor decode
// ************************************************************
// [RULE_01] Descriptor field split
assign op_byte = cmd_cdb_i[7:0];
assign mode_bits = cmd_cdb_i[12:8];
assign id_byte = cmd_cdb_i[23:16];
assign key_val = cdb_field24(cmd_cdb_i, 4'd3);
assign alloc_val = cdb_field24(cmd_cdb_i, 4'd6);
// [RULE_06] Other opcodes pass by
assign is_ours = (op_byte == `DRRB_OPCODE);
// [RULE_01] [RULE_02] Argument check
assign args_ok = (mode_bits == `DRRB_MODE) && (id_byte == `DRRB_BUF_ID)
    && (alloc_val == `DRRB_ALLOC_LEN) && report_en;
assign take_cmd = cmd_valid_i & cmd_ready_o;

// ************************************************************
// Sequence tracking and transfer control
// ************************************************************
// Reset command wins over an arm request taken in the same cycle
always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        seq_q <= SEQ_IDLE;
        xf_q <= XF_IDLE;
        zero_fill_q <= 1'b1;
        idx_q <= 9'h000;
        cmd_ready_o <= 1'b0;
        cmd_taken_o <= 1'b0;
        served_q <= 16'h0000;
        rejected_q <= 16'h0000;
    end
    else
    begin
        cmd_taken_o <= 1'b0;
        case (xf_q)
            XF_IDLE:
            begin
                cmd_ready_o <= 1'b1;
                if (take_cmd && is_ours)
                begin
                    cmd_ready_o <= 1'b0;
                    cmd_taken_o <= 1'b1;
                    xf_q <= XF_SEND;
                    idx_q <= 9'h000;
                    zero_fill_q <= 1'b1;
                    if (args_ok && key_val == `DRRB_KEY_ARM)
                        seq_q <= SEQ_ARMED;
                    // [RULE_03] Report only after arming
                    else if (args_ok && key_val == `DRRB_KEY_FETCH
                        && seq_q == SEQ_ARMED)
                    begin
                        zero_fill_q <= 1'b0;
                        seq_q <= SEQ_IDLE;
                        served_q <= served_q + 16'h0001;
                    end
                    // [RULE_03] Wrong argument or order
                    else
                    begin
                        seq_q <= SEQ_IDLE;
                        rejected_q <= rejected_q + 16'h0001;
                    end
                end
                // [RULE_06] Foreign command acknowledged only
                else if (take_cmd)
                    cmd_taken_o <= 1'b1;
            end
            XF_SEND:
            begin
                cmd_ready_o <= 1'b0;
                if (push)
                begin
                    idx_q <= idx_q + 9'h001;
                    if (idx_q == `DRRB_RPT_LAST)
                    begin
                        xf_q <= XF_IDLE;
                        cmd_ready_o <= 1'b1;
                    end
                end
            end
            default:
            begin
                xf_q <= XF_IDLE;
                cmd_ready_o <= 1'b0;
            end
        endcase
        // [RULE_04] Reset command drops progress
        if (reset_command_i)
            seq_q <= SEQ_IDLE;
    end
end

// ************************************************************
// Report byte generation
// ************************************************************
// [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11] Word per field
// [RULE_12] [RULE_13] [RULE_14] [RULE_15] [RULE_16] [RULE_17] Byte order
// [RULE_18] Low byte first, zero from offset 84 on
assign next_byte = (zero_fill_q || idx_q >= `DRRB_RPT_DEF_END) ? 8'h00
    : lane_of(rpt_mem_q[idx_q[6:2]], idx_q[1:0]);
assign push = (xf_q == XF_SEND) & buf_in_ready;

// Two-entry buffer holds bytes while the sink stalls
drrb_byte_buf u_buf (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(xf_q == XF_SEND),
    .in_data_i({idx_q == `DRRB_RPT_LAST, next_byte}),
    .in_ready_o(buf_in_ready),
    .out_valid_o(data_valid_o),
    .out_data_o(buf_out),
    .out_ready_i(data_ready_i)
);

assign data_byte_o = buf_out[7:0];
assign data_last_o = buf_out[8];

// ************************************************************
// Avalon-MM slave
// ************************************************************
// One wait cycle, then a single cycle with waitrequest low
assign bus_req = avs_read_i | avs_write_i;
assign bus_ack = bus_req & ~avs_waitrequest_o;
assign rpt_hit = (avs_address_i <= `DRRB_REG_RPT_LAST);

// Read data captured during the wait cycle, held through the ack
always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= 32'h00000000;
    end
    else
    begin
        avs_waitrequest_o <= 1'b1;
        if (bus_req && avs_waitrequest_o)
        begin
            avs_waitrequest_o <= 1'b0;
            if (rpt_hit)
                avs_readdata_o <= rpt_mem_q[avs_address_i];
            else if (avs_address_i == `DRRB_REG_CTRL)
                avs_readdata_o <= ctrl_q;
            else if (avs_address_i == `DRRB_REG_STATUS)
                avs_readdata_o <= {rejected_q[7:0], served_q[7:0], 12'h000,
                    seq_q, xf_q};
            else
                avs_readdata_o <= 32'h00000000;
        end
    end
end

// Writes land on the acknowledge edge only
always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        ctrl_q <= `DRRB_CTRL_RST;
        for (i = 0; i < `DRRB_RPT_WORDS; i = i + 1)
            rpt_mem_q[i] <= 32'h00000000;
    end
    else if (bus_ack && avs_write_i)
    begin
        if (rpt_hit)
            rpt_mem_q[avs_address_i] <= merge_be(rpt_mem_q[avs_address_i],
                avs_writedata_i, avs_byteenable_i);
        else if (avs_address_i == `DRRB_REG_CTRL)
            ctrl_q <= merge_be(ctrl_q, avs_writedata_i, avs_byteenable_i)
                & 32'h00000001;
    end
end

endmodule // drrb_report

/* verification/drrb_report_chk.sv */
/*
 * Port checker of the report reader.
 * Assumes a bind onto drrb_report, one clock, synchronous reset.
 */
`timescale 1ns/1ps
module drrb_report_chk (
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Register bus
    input wire avs_read_i,
    input wire avs_write_i,
    input wire avs_waitrequest_o,
    // Command port
    input wire cmd_valid_i,
    input wire [71:0] cmd_cdb_i,
    input wire cmd_ready_o,
    input wire cmd_taken_o,
    // Byte stream
    input wire data_valid_o,
    input wire [7:0] data_byte_o,
    input wire data_last_o,
    input wire data_ready_i
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    reg [9:0] beat_q;
    // Command take and report take
    sequence s_take;
        cmd_valid_i && cmd_ready_o;
    endsequence
    sequence s_take_rpt;
        s_take ##0 cmd_cdb_i[7:0] == 8'h3c;
    endsequence
    // Beats since the last end of report
    always @(posedge core_clk_i)
        if (sys_rst_i || (data_valid_o && data_ready_i && data_last_o))
            beat_q <= 10'h000;
        else if (data_valid_o && data_ready_i)
            beat_q <= beat_q + 10'h001;
    chk_take_ack: assert property (s_take |=> cmd_taken_o)
        else $error("command take not acknowledged");
    chk_ack_pulse: assert property (cmd_taken_o |=> !cmd_taken_o)
        else $error("take pulse too long");
    chk_busy_send: assert property (s_take_rpt |=> !cmd_ready_o)
        else $error("ready stayed up after report take");
    chk_first_byte: assert property (s_take_rpt |-> ##[3:40] data_valid_o)
        else $error("no report byte after take");
    chk_last_beat: assert property (data_valid_o && data_last_o |-> beat_q == 10'h1ff)
        else $error("last marker off byte 511");
    chk_stall_hold: assert property (data_valid_o && !data_ready_i |=>
        data_valid_o && $stable(data_byte_o) && $stable(data_last_o))
        else $error("stream changed during stall");
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("bus request not answered");
    chk_bus_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=>
        avs_waitrequest_o && !cmd_ready_o && !cmd_taken_o && !data_valid_o)
        else $error("outputs active after reset");
endmodule // drrb_report_chk

bind drrb_report drrb_report_chk chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .cmd_valid_i(cmd_valid_i), .cmd_cdb_i(cmd_cdb_i), .cmd_ready_o(cmd_ready_o),
    .cmd_taken_o(cmd_taken_o), .data_valid_o(data_valid_o), .data_byte_o(data_byte_o),
    .data_last_o(data_last_o), .data_ready_i(data_ready_i));

/* verification/drrb_host_sink.sv */
/*
 * Host-side sink of the report stream, prompt or stalling at random.
 * Assumes the reader's valid/ready stream on one clock.
 */
`timescale 1ns/1ps
module drrb_host_sink (
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Stream in
    input wire data_valid_i,
    input wire [7:0] data_byte_i,
    input wire data_last_i,
    // Stall control and ready
    input wire slow_i,
    output reg data_ready_o
);
    // Received beats, last flag in bit 8
    logic [8:0] got[$];
    // Accept beats, stall at random when slow
    always @(posedge core_clk_i)
    begin
        if (!sys_rst_i && data_valid_i && data_ready_o)
            got.push_back({data_last_i, data_byte_i});
        data_ready_o <= !sys_rst_i && (!slow_i || $urandom % 2 == 1);
    end
endmodule // drrb_host_sink

/* verification/test_drrb_report.sv */
/*
 * Bench of the report reader: registers, report sequences, bad requests.
 * Assumes the design, its defines header, checker and host sink.
 */
`timescale 1ns/1ps
`include "drrb_defs.vh"
module test_drrb_report;
    // Stimulus, outputs and model state
    reg core_clk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [4:0] adr = 5'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [3:0] be = 4'h0;
    reg cv = 1'b0;
    reg [71:0] cdb = 72'h0;
    reg rcmd = 1'b0;
    reg slow = 1'b0;
    wire [31:0] rdata;
    wire wt, crdy, ctk, dv, dl, drdy;
    wire [7:0] db;
    integer words[0:20];
    integer armed, en, err_count, checks, i, j, k;
    reg [31:0] q;
    reg [71:0] arm_c, fet_c;
    reg [71:0] bad[0:3];
    // Clock of 5 ns
    always #2.5 core_clk_i = ~core_clk_i;
    // Design and host sink
    drrb_report dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .cmd_valid_i(cv), .cmd_cdb_i(cdb),
        .reset_command_i(rcmd), .cmd_ready_o(crdy), .cmd_taken_o(ctk), .data_valid_o(dv),
        .data_byte_o(db), .data_last_o(dl), .data_ready_i(drdy));
    drrb_host_sink sink (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .data_valid_i(dv),
        .data_byte_i(db), .data_last_i(dl), .slow_i(slow), .data_ready_o(drdy));
    // Verdict and end of run
    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // Compare one result
    task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    begin
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    end
    endtask
    // One bounded wait step, up to the next rising edge
    task automatic step(input string w, inout integer n);
    begin
        n++;
        if (n > 5000)
        begin
            err_count++;
            $display("ERROR %s expected done seen timeout", w);
            report_and_stop;
        end
        else
            @(posedge core_clk_i);
    end
    endtask
    // One Avalon access, held until the edge that samples waitrequest low
    task automatic bus(input bit w, input [4:0] a, input [31:0] d, input [3:0] b);
        integer n;
    begin
        n = 0;
        @(posedge core_clk_i);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        be <= b;
        step("waitrequest", n);
        while (wt !== 1'b0)
            step("waitrequest", n);
        // Values seen here are those sampled at this edge
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    end
    endtask
    // Register write into design and model
    task automatic wreg(input [4:0] a, input [31:0] d, input [3:0] b);
    begin
        bus(1'b1, a, d, b);
        for (j = 0; j < 4; j++)
            if (b[j] && a < 5'h15)
                words[a][8 * j +: 8] = d[8 * j +: 8];
        if (a == `DRRB_REG_CTRL && b[0])
            en = d[0];
    end
    endtask
    // Register read against model
    task automatic rreg(input [4:0] a);
    begin
        bus(1'b0, a, 32'h0, 4'hf);
        cmp("register", a < 5'h15 ? words[a] : a == `DRRB_REG_CTRL ? en : 0, q);
    end
    endtask
    // Build a descriptor, byte 0 in the low bits
    function automatic [71:0] mk(input [4:0] m, input [7:0] b, input [23:0] y, input [23:0] l);
        mk = {l[7:0], l[15:8], l[23:16], y[7:0], y[15:8], y[23:16], b, 3'h0, m, `DRRB_OPCODE};
    endfunction
    // Expected stream beat
    function automatic [8:0] ebyte(input integer n, input integer r);
        ebyte = {n == 511, (r != 0 && n < 84) ? words[n / 4][8 * (n % 4) +: 8] : 8'h00};
    endfunction
    // Send one command, check take and the whole stream
    task automatic issue(input [71:0] c);
        integer n, rpt, good;
    begin
        good = c[12:8] == `DRRB_MODE && c[23:16] == `DRRB_BUF_ID && en == 1 &&
            {c[55:48], c[63:56], c[71:64]} == `DRRB_ALLOC_LEN;
        rpt = good && {c[31:24], c[39:32], c[47:40]} == `DRRB_KEY_FETCH && armed;
        if (c[7:0] == `DRRB_OPCODE)
            armed = good && {c[31:24], c[39:32], c[47:40]} == `DRRB_KEY_ARM;
        sink.got.delete();
        n = 0;
        @(posedge core_clk_i);
        cv <= 1'b1;
        cdb <= c;
        step("command ready", n);
        while (crdy !== 1'b1)
            step("command ready", n);
        // Taken at this edge, so the request drops here
        cv <= 1'b0;
        step("command taken", n);
        cmp("taken", 32'h1, ctk);
        while (c[7:0] == `DRRB_OPCODE && sink.got.size() < 512)
            step("report", n);
        // A few idle edges so that stray beats would show
        repeat (4) @(posedge core_clk_i);
        cmp("byte count", c[7:0] == `DRRB_OPCODE ? 512 : 0, sink.got.size());
        for (i = 0; i < sink.got.size(); i++)
            cmp("report byte", ebyte(i, rpt), sink.got[i]);
    end
    endtask
    // Main sequence
    initial
    begin
        err_count = 0;
        checks = 0;
        armed = 0;
        en = 1;
        for (k = 0; k < 21; k++)
            words[k] = 0;
        q = $urandom(32'h01a1);
        arm_c = mk(`DRRB_MODE, `DRRB_BUF_ID, `DRRB_KEY_ARM, `DRRB_ALLOC_LEN);
        fet_c = mk(`DRRB_MODE, `DRRB_BUF_ID, `DRRB_KEY_FETCH, `DRRB_ALLOC_LEN);
        bad[0] = mk(5'h02, `DRRB_BUF_ID, `DRRB_KEY_FETCH, `DRRB_ALLOC_LEN);
        bad[1] = mk(`DRRB_MODE, 8'h02, `DRRB_KEY_FETCH, `DRRB_ALLOC_LEN);
        bad[2] = mk(`DRRB_MODE, `DRRB_BUF_ID, 24'h000003, `DRRB_ALLOC_LEN);
        bad[3] = mk(`DRRB_MODE, `DRRB_BUF_ID, `DRRB_KEY_FETCH, 24'h000100);
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (k = 0; k < 25; k++)
            rreg(k[4:0]);
        bus(1'b0, `DRRB_REG_STATUS, 32'h0, 4'hf);
        cmp("status idle", 32'h5, {28'h0, q[3:0]});
        $display("test reset values done");
        for (k = 0; k < 21; k++)
            wreg(k[4:0], $urandom, 4'hf);
        wreg(5'h03, 32'h0, 4'h5);
        wreg(5'h16, 32'hffffffff, 4'hf);
        for (k = 0; k < 25; k++)
            rreg(k[4:0]);
        $display("test registers done");
        // report layout, prompt and stalling host
        for (k = 0; k < 2; k++)
        begin
            slow <= k[0];
            issue(arm_c);
            issue(fet_c);
        end
        $display("test report done");
        issue(fet_c);
        issue(arm_c);
        issue(72'h12);
        wreg(5'h05, $urandom, 4'hf);
        issue(fet_c);
        for (k = 0; k < 4; k++)
        begin
            issue(arm_c);
            issue(bad[k]);
            issue(fet_c);
        end
        $display("test order and fields done");
        issue(arm_c);
        @(posedge core_clk_i);
        rcmd <= 1'b1;
        @(posedge core_clk_i);
        rcmd <= 1'b0;
        armed = 0;
        issue(fet_c);
        issue(arm_c);
        issue(fet_c);
        wreg(`DRRB_REG_CTRL, 32'h0, 4'hf);
        issue(arm_c);
        issue(fet_c);
        wreg(`DRRB_REG_CTRL, 32'h1, 4'hf);
        $display("test reset command and enable done");
        issue(arm_c);
        wreg(`DRRB_REG_CTRL, 32'h0, 4'hf);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        armed = 0;
        en = 1;
        for (k = 0; k < 21; k++)
            words[k] = 0;
        rreg(`DRRB_REG_CTRL);
        rreg(5'h07);
        bus(1'b0, `DRRB_REG_STATUS, 32'h0, 4'hf);
        cmp("status reset", 32'h5, q);
        for (k = 0; k < 21; k++)
            wreg(k[4:0], $urandom, 4'hf);
        issue(fet_c);
        issue(arm_c);
        issue(fet_c);
        $display("test hardware reset done");
        report_and_stop;
    end
endmodule // test_drrb_report
